// *** hw/uart_bridge_consts.svh ***
// constants for the uart bridge with flow-control detection
`ifndef UART_BRIDGE_CONSTS_SVH
`define UART_BRIDGE_CONSTS_SVH
`define CLK_HZ          20000000
`define MAX_BAUD        1000000
`define BAUD_UNSUPPORTED 921600
`define DEF_BAUD        115200
`define DIV_W           16
`define MIN_DIV         (`CLK_HZ / `MAX_BAUD)
`endif

// *** hw/uart_bridge_pkg.sv ***
// types for the uart bridge with flow-control detection
package uart_bridge_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_DETECT = 4'b0010,
    ST_FLOW   = 4'b0100,
    ST_NOFLOW = 4'b1000
  } det_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } byte_bus_t;

  typedef struct packed {
    logic [9:0]  sh;
    logic [3:0]  bits;
    logic [15:0] cnt;
    logic        busy;
  } shifter_t;
endpackage

// *** hw/uart_bridge_flow_detect.sv ***
// uart bridge between host byte stream and target uart, with flow-control detection
// Operation
// RULE1: baud divider configurable up to 1 Mbps; 921600 bps not required.
// RULE2: without an open host terminal all target-facing pins are released.
// RULE3: host asserts dtr before the bridge drives any target pin.
// RULE4: every dtr rising edge starts a fresh flow-control detection.
// RULE5: during detection drive cts, sample rts at first byte moved.
// RULE6: rts high at sample: release cts, ignore rts.
// RULE7: flow control found: keep driving cts until reset or new dtr.
// RULE8: after reset all target uart lines start released.
// RULE9: lines crossed: target rts->our cts_in, target txd->our rxd, etc.
// RULE10: without flow control target may reuse rts/cts; bridge leaves them.
// RULE11: one rts sample per detection, latched until dtr or reset.
`timescale 1ns/1ns
`default_nettype none
`include "uart_bridge_consts.svh"
module uart_bridge_flow_detect
  import uart_bridge_pkg::*;
#(
  parameter logic [`DIV_W-1:0] BAUD_DIV = `DIV_W'(`CLK_HZ / `DEF_BAUD)
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // host side
  input  wire logic       dtr,
  input  wire logic [7:0] host_tx_data,
  input  wire logic       host_tx_valid,
  output logic            host_tx_ready,
  output logic [7:0]      host_rx_data,
  output logic            host_rx_valid,
  output logic            hw_flow_control,
  // target pins: tx toward target rxd, rx from target txd
  output logic txd_o,
  output logic txd_oe_n,
  input  wire logic rxd_i,
  // our rts toward target cts, our cts from target rts
  output logic rts_o,
  output logic rts_oe_n,
  input  wire logic cts_i
);
  //----------------------------------------
  // state
  //----------------------------------------
  typedef struct packed {
    det_state_t st;
    logic       dtr_prev;
    shifter_t   tx;
    shifter_t   rx;
    logic [1:0] rx_sync;
    byte_bus_t  rx_out;
    logic       tx_rdy;
    logic       fc;
  } state_t;

  state_t s_q, s_d;
  logic   dtr_rise;
  logic   active;
  logic   rx_bit;
  logic   tx_start;
  logic   moved;
  logic [`DIV_W-1:0] div_eff;

  //----------------------------------------
  // control decode
  //----------------------------------------
  // clamp divider so rate never exceeds the maximum
  assign div_eff = (BAUD_DIV < `DIV_W'(`MIN_DIV)) ? `DIV_W'(`MIN_DIV) : BAUD_DIV; // [RULE1]
  assign dtr_rise = dtr && !s_q.dtr_prev;
  assign active   = (s_q.st != ST_IDLE); // [RULE3]
  assign rx_bit   = s_q.rx_sync[1];
  // with flow control, target rts low means target can accept
  // ready drops the cycle after accept, so valid may stay up
  assign tx_start = active && host_tx_valid && s_q.tx_rdy &&
                    !(s_q.st == ST_FLOW && cts_i);

  //----------------------------------------
  // next state
  //----------------------------------------
  // one combinational copy of the whole state; each
  // section below touches only its own fields, except dtr low, which also idles both shifters and tx_rdy
  always_comb begin
    s_d = s_q;
    moved = 1'b0;
    s_d.dtr_prev = dtr;
    s_d.rx_sync  = {s_q.rx_sync[0], rxd_i};
    s_d.rx_out.valid = 1'b0;
    s_d.tx_rdy = 1'b0;

    //----------------------------------------
    // transmitter
    //----------------------------------------
    if (s_q.tx.busy) begin
      if (s_q.tx.cnt == '0) begin
        s_d.tx.cnt = div_eff - `DIV_W'(1);
        s_d.tx.sh  = {1'b1, s_q.tx.sh[9:1]};
        if (s_q.tx.bits == 4'h0) begin
          s_d.tx.busy = 1'b0;
        end else begin
          s_d.tx.bits = s_q.tx.bits - 4'h1;
        end
      end else begin
        s_d.tx.cnt = s_q.tx.cnt - `DIV_W'(1);
      end
    end else begin
      s_d.tx_rdy = active && !tx_start;
      if (tx_start) begin
        s_d.tx.sh   = {1'b1, host_tx_data, 1'b0};
        s_d.tx.bits = 4'h9;
        s_d.tx.cnt  = div_eff - `DIV_W'(1);
        s_d.tx.busy = 1'b1;
        moved = 1'b1;
      end
    end

    //----------------------------------------
    // receiver, sampled mid-bit
    //----------------------------------------
    // two-flop synchroniser; only its second stage is read
    if (s_q.rx.busy) begin
      if (s_q.rx.cnt == '0) begin
        s_d.rx.cnt = div_eff - `DIV_W'(1);
        s_d.rx.sh  = {rx_bit, s_q.rx.sh[9:1]};
        if (s_q.rx.bits == 4'h0) begin
          s_d.rx.busy = 1'b0;
          // framing error (stop low) drops the byte
          if (rx_bit) begin
            s_d.rx_out.data  = s_q.rx.sh[9:2];
            s_d.rx_out.valid = 1'b1;
            moved = 1'b1;
          end
        end else begin
          s_d.rx.bits = s_q.rx.bits - 4'h1;
        end
      end else begin
        s_d.rx.cnt = s_q.rx.cnt - `DIV_W'(1);
      end
    end else if (active && !rx_bit) begin
      s_d.rx.busy = 1'b1;
      s_d.rx.bits = 4'h9;
      s_d.rx.cnt  = {1'b0, div_eff[`DIV_W-1:1]};
    end

    //----------------------------------------
    // flow-control detection
    //----------------------------------------
    case (s_q.st)
      ST_IDLE: begin
        s_d.fc = 1'b0;
      end
      ST_DETECT: begin
        // single sample; later bytes leave the decision alone
        if (moved) begin // [RULE5]
          s_d.fc = !cts_i; // [RULE11]
          s_d.st = cts_i ? ST_NOFLOW : ST_FLOW; // [RULE6]
        end
      end
      ST_FLOW: begin
        s_d.fc = 1'b1; // [RULE7]
      end
      ST_NOFLOW: begin
        s_d.fc = 1'b0; // [RULE10]
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    // a fresh dtr overrides any decision and restarts detection
    // dropping dtr aborts a byte in flight; host must reopen
    if (dtr_rise) begin
      s_d.st = ST_DETECT; // [RULE4]
      s_d.fc = 1'b0;
    end else if (!dtr) begin
      s_d.st = ST_IDLE; // [RULE2]
      s_d.fc = 1'b0;
      s_d.tx.busy = 1'b0;
      s_d.tx.sh   = 10'h3FF;
      s_d.rx.busy = 1'b0;
      s_d.tx_rdy  = 1'b0;
    end
  end

  //----------------------------------------
  // state register
  //----------------------------------------
  // reset leaves the shifter idle high and both pins released
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{st: ST_IDLE, tx: '{sh: 10'h3FF, default: '0}, // [RULE8]
               rx_sync: 2'b11, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  //----------------------------------------
  // output registers
  //----------------------------------------
  // pins sit in registers so oe and level change together
  logic txd_q, txd_oe_n_q, rts_oe_n_q, rts_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      txd_q      <= 1'b1;
      txd_oe_n_q <= 1'b1;
      rts_oe_n_q <= 1'b1;
      rts_q      <= 1'b0;
    end else begin
      txd_q      <= s_d.tx.sh[0];
      // always the ready level; only its enable moves
      rts_q      <= 1'b0;
      txd_oe_n_q <= (s_d.st == ST_IDLE); // [RULE2] [RULE9]
      // cts driven while detecting or with flow control, released otherwise
      rts_oe_n_q <= !(s_d.st == ST_DETECT || s_d.st == ST_FLOW); // [RULE5] [RULE7]
    end
  end

  //----------------------------------------
  // port map
  //----------------------------------------
  assign txd_o           = txd_q;
  assign txd_oe_n        = txd_oe_n_q;
  assign rts_o           = rts_q;
  assign rts_oe_n        = rts_oe_n_q;
  assign host_tx_ready   = s_q.tx_rdy;
  assign host_rx_data    = s_q.rx_out.data;
  assign host_rx_valid   = s_q.rx_out.valid;
  assign hw_flow_control = s_q.fc;
endmodule
`default_nettype wire

// *** tb/uart_bridge_assertions.sv ***
// port checker for the uart bridge with flow detection
`timescale 1ns/1ns
`default_nettype none
module uart_bridge_assertions (
  input wire logic clk, rst, dtr, host_tx_valid, host_tx_ready, host_rx_valid,
  input wire logic hw_flow_control, txd_o, txd_oe_n, rts_oe_n, cts_i
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_off; (!dtr)[*4] |-> txd_oe_n && rts_oe_n && !host_rx_valid; endproperty
  a_off: assert property (p_off) else $error("pin driven while closed");
  property p_rst; $fell(rst) |-> txd_oe_n && rts_oe_n && txd_o && !hw_flow_control; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_open; $rose(dtr) ##1 dtr |-> ##1 !txd_oe_n && !rts_oe_n; endproperty
  a_open: assert property (p_open) else $error("no detect");
  property p_samp; $rose(hw_flow_control) |-> !$past(cts_i) || !$past(cts_i, 2); endproperty
  a_samp: assert property (p_samp) else $error("flow with rts high");
  property p_free; host_tx_valid && host_tx_ready && cts_i && dtr && !hw_flow_control
    ##1 dtr[*4] |-> rts_oe_n; endproperty
  a_free: assert property (p_free) else $error("cts kept");
  property p_keep; hw_flow_control && $past(hw_flow_control) && dtr |-> !rts_oe_n; endproperty
  a_keep: assert property (p_keep) else $error("cts dropped");
  property p_hold; dtr && $past(dtr) && $past(hw_flow_control) |-> hw_flow_control; endproperty
  a_hold: assert property (p_hold) else $error("decision lost");
  property p_bit; $fell(txd_o) && !txd_oe_n |-> (!txd_o)[*8]; endproperty
  a_bit: assert property (p_bit) else $error("bit too short");
  c_open: cover property ($rose(dtr));
  c_flow: cover property ($rose(hw_flow_control));
  c_free: cover property ($rose(rts_oe_n) && dtr);
endmodule
bind uart_bridge_flow_detect uart_bridge_assertions uart_bridge_assertions_inst (.*);
`default_nettype wire

// *** tb/target_uart_model.sv ***
// target uart partner: 8n1 at 20 clocks a bit
`timescale 1ns/1ns
`default_nettype none
module target_uart_model (
  input  wire logic clk,
  input  wire logic txd,
  input  wire logic txd_oe_n,
  output logic      rxd = 1'b1,
  // rts is the target's own; the bench sets it
  output logic      rts = 1'b1
);
  // released line reads idle, as with a pull-up
  wire line = txd_oe_n | txd;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (20) @(posedge clk);
    end
  endtask
  task automatic recv(output logic [7:0] b);
    @(negedge line);
    repeat (30) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = line;
      repeat (20) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// *** tb/uart_bridge_flow_detect_tb.sv ***
// bench for the uart bridge with flow detection
`timescale 1ns/1ns
`default_nettype none
module uart_bridge_flow_detect_tb;
  logic clk = 0, rst = 1, dtr = 0, tx_v = 0, tx_r, rx_v, fc, txd, txd_oe_n, rts_oe_n, rxd, cts;
  logic rts_v;
  logic [7:0] tx_d = 8'h00, rx_d, got;
  int failures = 0, n_checks = 0;
  always #25 clk = ~clk;
  uart_bridge_flow_detect #(.BAUD_DIV(16'h0014)) uart_bridge_flow_detect_inst (.clk, .rst,
    .dtr, .host_tx_data(tx_d), .host_tx_valid(tx_v), .host_tx_ready(tx_r), .host_rx_data(rx_d),
    .host_rx_valid(rx_v), .hw_flow_control(fc), .txd_o(txd), .txd_oe_n, .rxd_i(rxd),
    .rts_o(rts_v), .rts_oe_n, .cts_i(cts));
  target_uart_model target_uart_model_inst (.clk, .txd, .txd_oe_n, .rxd, .rts(cts));
  task automatic chk(input string n, input logic [7:0] e, s);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic hsend(input logic [7:0] b);
    tx_d = b;
    tx_v = 1'b1;
    while (tx_r !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1 tx_v = 1'b0;
  endtask
  task automatic t_closed;
    chk("oe", 8'h03, {txd_oe_n, rts_oe_n});
    tx_v = 1'b1;
    repeat (40) @(posedge clk);
    #1 chk("oe", 8'h03, {txd_oe_n, rts_oe_n});
    chk("fc", 8'h00, fc);
    tx_v = 1'b0;
    $display("closed done");
  endtask
  task automatic t_open(input logic fcu, input logic [7:0] b);
    dtr = 1'b0;
    target_uart_model_inst.rts = !fcu;
    repeat (4) @(posedge clk);
    #1 dtr = 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("oe", 8'h00, {txd_oe_n, rts_oe_n});
    chk("rts_o", 8'h00, rts_v);
    fork
      target_uart_model_inst.recv(got);
      hsend(b);
    join
    chk("txd", b, got);
    repeat (4) @(posedge clk);
    #1 chk("fc", fcu, fc);
    chk("rts_oe_n", !fcu, rts_oe_n);
    target_uart_model_inst.rts = fcu;
    fork
      target_uart_model_inst.send(~b);
      while (rx_v !== 1'b1) @(posedge clk) #1;
    join
    chk("rxd", ~b, rx_d);
    chk("fc", fcu, fc);
    $display("open done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    t_closed;
    t_open(1'b1, 8'hA5);
    t_open(1'b0, 8'h3C);
    t_open(1'b1, 8'h81);
    test_done;
  end
  // about six times the expected run
  initial begin
    #400000;
    failures++;
    test_done;
  end
endmodule
`default_nettype wire
